// file: inc/bio_pkg.sv
`default_nettype none
package bio_pkg;
  localparam int BIO_WORD_W = 16;
  localparam int BIO_ADDR_W = 11;
  localparam int BIO_DISP_W = 8;
  localparam int BIO_CNT_W = 4;
  localparam int BIO_OFS_W = 5;
  // hardware base sits in word bits 11..1 (lsb-0 numbering)
  localparam int BIO_BASE_LSB = 1;
  localparam int BIO_BASE_MSB = 11;
  localparam logic [BIO_OFS_W-1:0] BIO_FULL_CNT = 5'h10;
  localparam logic [BIO_OFS_W-1:0] BIO_LAST_CNT = 5'h01;
  localparam logic [BIO_OFS_W-1:0] BIO_OFS_STEP = 5'h01;
  localparam logic [1:0] BIO_TOP_LINES = 2'h0;

  typedef enum logic [2:0] {
    BIO_TEST_BIT_OP,
    BIO_SET_ONE_OP,
    BIO_SET_ZERO_OP,
    BIO_MULTI_BIT_LOAD_OP,
    BIO_MULTI_BIT_STORE_OP
  } bio_op_t;

  function automatic logic [BIO_ADDR_W-1:0] bio_hw_base(
      input logic [BIO_WORD_W-1:0] w);
    bio_hw_base = w[BIO_BASE_MSB:BIO_BASE_LSB];
  endfunction

  function automatic logic [BIO_ADDR_W-1:0] bio_sext(
      input logic [BIO_DISP_W-1:0] d);
    bio_sext = {{(BIO_ADDR_W-BIO_DISP_W){d[BIO_DISP_W-1]}}, d};
  endfunction

  function automatic logic bio_is_single(input bio_op_t op);
    bio_is_single = (op == BIO_TEST_BIT_OP) || (op == BIO_SET_ONE_OP) ||
                    (op == BIO_SET_ZERO_OP);
  endfunction

  function automatic logic bio_is_out(input bio_op_t op);
    bio_is_out = (op == BIO_SET_ONE_OP) || (op == BIO_SET_ZERO_OP) ||
                 (op == BIO_MULTI_BIT_LOAD_OP);
  endfunction
endpackage
`default_nettype wire

// file: inc/bio_addr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bio_addr_if;
  import bio_pkg::*;
  logic [BIO_WORD_W-1:0] base_word;
  logic [BIO_DISP_W-1:0] disp;
  logic use_disp;
  logic [BIO_OFS_W-1:0] offset;
  logic [BIO_ADDR_W-1:0] bit_addr;
  modport gen (input base_word, input disp, input use_disp, input offset,
               output bit_addr);
  modport seq (output base_word, output disp, output use_disp,
               output offset, input bit_addr);
endinterface
`default_nettype wire

// file: hw/bio_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none
module bio_addr_gen import bio_pkg::*; (
  bio_addr_if.gen ai
);
  wire logic [BIO_ADDR_W-1:0] base_w;
  wire logic [BIO_ADDR_W-1:0] disp_w;
  wire logic [BIO_ADDR_W-1:0] ofs_w;

  // word bits 15..12 and 0 simply never reach the adder
  assign base_w = bio_hw_base(ai.base_word);
  assign disp_w = ai.use_disp ? bio_sext(ai.disp) : '0;
  assign ofs_w = {{(BIO_ADDR_W-BIO_OFS_W){1'b0}}, ai.offset};
  // wraps modulo 2^11, as the address lines do
  assign ai.bit_addr = base_w + disp_w + ofs_w;
endmodule
`default_nettype wire

// file: hw/bio_unit.sv
`timescale 1ns/1ns
`default_nettype none
module bio_unit import bio_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire bio_op_t op_kind,
  input wire logic [BIO_WORD_W-1:0] base_pointer_word,
  input wire logic [BIO_DISP_W-1:0] displacement,
  input wire logic [BIO_CNT_W-1:0] bit_count,
  input wire logic [BIO_WORD_W-1:0] write_data,
  output logic [1:0] addr_top,
  output logic [BIO_ADDR_W-1:0] bit_addr,
  output logic serial_bit_out,
  output logic bit_output_strobe,
  input wire logic serial_bit_in,
  output logic busy,
  output logic done,
  output logic test_result,
  output logic [BIO_WORD_W-1:0] read_data
);
  typedef enum logic [1:0] {BIO_IDLE, BIO_ADDR, BIO_XFER} bio_state_t;

  bio_state_t state_r;
  bio_op_t op_r;
  logic [BIO_WORD_W-1:0] base_r;
  logic [BIO_DISP_W-1:0] disp_r;
  logic [BIO_WORD_W-1:0] data_r;
  logic [BIO_OFS_W-1:0] cnt_r;
  logic [BIO_OFS_W-1:0] offset_r;
  logic [BIO_ADDR_W-1:0] bit_addr_r;
  logic serial_out_r;
  logic strobe_r;
  logic done_r;
  logic test_r;
  logic [BIO_WORD_W-1:0] rdata_r;

  bio_addr_if ai ();

  bio_addr_gen u_gen (
    .ai(ai)
  );

  ////////////////////////////////////////////////////////////////////////
  wire logic idle_w;
  wire logic accept_w;
  wire logic last_w;
  wire logic first_out_w;
  wire logic [BIO_OFS_W-1:0] cnt_in_w;
  wire logic [BIO_OFS_W-1:0] ofs_nxt;

  assign idle_w = (state_r == BIO_IDLE);
  assign accept_w = idle_w && op_valid;
  assign last_w = (cnt_r == BIO_LAST_CNT);
  assign cnt_in_w = (bit_count == '0) ? BIO_FULL_CNT
                                      : {1'b0, bit_count};
  assign ofs_nxt = offset_r + BIO_OFS_STEP;
  // while idle the generator looks straight at the request
  assign ai.base_word = idle_w ? base_pointer_word : base_r;
  assign ai.disp = idle_w ? displacement : disp_r;
  assign ai.use_disp = idle_w ? bio_is_single(op_kind)
                              : bio_is_single(op_r);
  assign ai.offset = idle_w ? '0 : ofs_nxt;
  assign first_out_w = (op_kind == BIO_SET_ONE_OP) ||
                       ((op_kind == BIO_MULTI_BIT_LOAD_OP) && write_data[0]);

  assign op_ready = idle_w;
  assign busy = !idle_w;
  assign addr_top = BIO_TOP_LINES;
  assign bit_addr = bit_addr_r;
  assign serial_bit_out = serial_out_r;
  assign bit_output_strobe = strobe_r;
  assign done = done_r;
  assign test_result = test_r;
  assign read_data = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // two cycles per bit: address settles, then strobe or input sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= BIO_IDLE;
      op_r <= BIO_TEST_BIT_OP;
      base_r <= '0;
      disp_r <= '0;
      data_r <= '0;
      cnt_r <= '0;
      offset_r <= '0;
      bit_addr_r <= '0;
      serial_out_r <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      unique case (state_r)
        BIO_IDLE: begin
          if (op_valid) begin
            op_r <= op_kind;
            base_r <= base_pointer_word;
            disp_r <= displacement;
            data_r <= write_data;
            cnt_r <= bio_is_single(op_kind) ? BIO_LAST_CNT : cnt_in_w;
            offset_r <= '0;
            bit_addr_r <= ai.bit_addr;
            serial_out_r <= first_out_w;
            state_r <= BIO_ADDR;
          end
        end
        BIO_ADDR: begin
          strobe_r <= bio_is_out(op_r);
          state_r <= BIO_XFER;
        end
        BIO_XFER: begin
          strobe_r <= 1'b0;
          if (last_w) begin
            serial_out_r <= 1'b0;
            state_r <= BIO_IDLE;
          end else begin
            cnt_r <= cnt_r - BIO_LAST_CNT;
            offset_r <= ofs_nxt;
            data_r <= data_r >> 1;
            bit_addr_r <= ai.bit_addr;
            serial_out_r <= (op_r == BIO_MULTI_BIT_LOAD_OP) && data_r[1];
            state_r <= BIO_ADDR;
          end
        end
      endcase
    end
  end

  // input bits land lsb first; the test op keeps its bit separately
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      test_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      done_r <= (state_r == BIO_XFER) && last_w;
      if ((state_r == BIO_XFER) && (op_r == BIO_TEST_BIT_OP)) begin
        test_r <= serial_bit_in;
      end
      if (accept_w && (op_kind == BIO_MULTI_BIT_STORE_OP)) begin
        rdata_r <= '0;
      end else if ((state_r == BIO_XFER) &&
                   (op_r == BIO_MULTI_BIT_STORE_OP)) begin
        rdata_r[offset_r[BIO_CNT_W-1:0]] <= serial_bit_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_bit_phase;
    (state_r == BIO_ADDR) && !strobe_r ##1 (state_r == BIO_XFER);
  endsequence

  sequence s_out_phase;
    !strobe_r ##1 strobe_r ##1 !strobe_r;
  endsequence

  property p_multi_base;
    @(posedge clk) disable iff (!rst_n)
    accept_w && !bio_is_single(op_kind) |=>
      bit_addr_r == $past(base_pointer_word[BIO_BASE_MSB:BIO_BASE_LSB]);
  endproperty
  a_multi_base: assert property (p_multi_base)
    else $error("multi-bit start address is not the hardware base");

  property p_single_disp;
    @(posedge clk) disable iff (!rst_n)
    accept_w && bio_is_single(op_kind) |=>
      bit_addr_r == bio_hw_base($past(base_pointer_word)) +
                    bio_sext($past(displacement));
  endproperty
  a_single_disp: assert property (p_single_disp)
    else $error("single-bit address is not base plus displacement");

  property p_top_zero;
    @(posedge clk) disable iff (!rst_n)
    busy |-> addr_top == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("top address lines not zero during bit cycle");

  property p_phase;
    @(posedge clk) disable iff (!rst_n)
    accept_w |=> s_bit_phase;
  endproperty
  a_phase: assert property (p_phase)
    else $error("bit cycle does not run address then transfer");

  property p_addr_stable;
    @(posedge clk) disable iff (!rst_n)
    strobe_r |-> $stable(bit_addr_r) && $stable(serial_out_r);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address or serial out moved under the strobe");

  property p_step;
    @(posedge clk) disable iff (!rst_n)
    (state_r == BIO_XFER) && !last_w |=>
      bit_addr_r == $past(bit_addr_r) + 11'h001;
  endproperty
  a_step: assert property (p_step)
    else $error("multi-bit address did not step by one");

  property p_set_one;
    @(posedge clk) disable iff (!rst_n)
    accept_w && (op_kind == BIO_SET_ONE_OP) |=>
      s_out_phase and (serial_out_r [*2]);
  endproperty
  a_set_one: assert property (p_set_one)
    else $error("set-one did not strobe a one on serial out");

  property p_no_strobe_in;
    @(posedge clk) disable iff (!rst_n)
    accept_w && !bio_is_out(op_kind) |=> !strobe_r [*3];
  endproperty
  a_no_strobe_in: assert property (p_no_strobe_in)
    else $error("strobe raised on an input operation");

  property p_single_done;
    @(posedge clk) disable iff (!rst_n)
    accept_w && bio_is_single(op_kind) |-> ##3 done && op_ready;
  endproperty
  a_single_done: assert property (p_single_done)
    else $error("single-bit operation did not finish in three cycles");
endmodule
`default_nettype wire

// file: verification/bio_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// decode and lamp latches on the far side of the bit port
module bio_far_model import bio_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [BIO_ADDR_W-1:0] bit_addr,
  input wire logic serial_bit_out,
  input wire logic bit_output_strobe,
  output logic serial_bit_in,
  output logic [3:0] lamps
);
  // four 32-bit windows at 000, 200, 400, 600
  wire logic dev_hit = (bit_addr[8:5] == 4'h0);
  wire logic lamp_hit = (bit_addr[10:2] == 9'h004);
  // parity pattern, so a wrong address reads back wrong
  assign serial_bit_in = dev_hit & (^bit_addr[4:0]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lamps <= 4'h0;
    end else if (bit_output_strobe && lamp_hit) begin
      lamps[bit_addr[1:0]] <= serial_bit_out;
    end
  end
endmodule
`default_nettype wire

// file: verification/bit_io_address_decode_test.sv
`timescale 1ns/1ns
`default_nettype none
module bit_io_address_decode_test;
  import bio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  bio_op_t op_kind = BIO_TEST_BIT_OP;
  logic [15:0] base_pointer_word = 16'h0000;
  logic [7:0] displacement = 8'h00;
  logic [3:0] bit_count = 4'h0;
  logic [15:0] write_data = 16'h0000;
  logic op_ready, serial_bit_out, bit_output_strobe, serial_bit_in;
  logic busy, done, test_result;
  logic [1:0] addr_top;
  logic [10:0] bit_addr, last_ea;
  logic [15:0] read_data;
  logic [3:0] lamps;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [10:0] t_base [8] = '{11'h400, 11'h400, 11'h400, 11'h400,
                              11'h000, 11'h21f, 11'h61e, 11'h7ff};
  logic [7:0] t_disp [8] = '{8'hff, 8'h7f, 8'h80, 8'h1c,
                             8'h05, 8'h00, 8'h01, 8'h01};

  bio_unit u_bio_unit (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_ready(op_ready), .op_kind(op_kind),
    .base_pointer_word(base_pointer_word), .displacement(displacement),
    .bit_count(bit_count), .write_data(write_data), .addr_top(addr_top),
    .bit_addr(bit_addr), .serial_bit_out(serial_bit_out),
    .bit_output_strobe(bit_output_strobe), .serial_bit_in(serial_bit_in),
    .busy(busy), .done(done), .test_result(test_result),
    .read_data(read_data));
  bio_far_model u_bio_far_model (.clk(clk), .rst_n(rst_n),
    .bit_addr(bit_addr), .serial_bit_out(serial_bit_out),
    .bit_output_strobe(bit_output_strobe), .serial_bit_in(serial_bit_in),
    .lamps(lamps));

  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic exp_in(input logic [10:0] a);
    return (a[8:5] == 4'h0) ? ^a[4:0] : 1'b0;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // entered just after an edge; request goes out at once, so calls
  // follow each other back to back in the cycle that done is high
  task automatic run_op(input bio_op_t k, input logic [10:0] b,
      input logic [7:0] d, input logic [3:0] n, input logic [15:0] wd);
    logic single, outp, eo;
    int bits, s, t;
    single = k inside {BIO_TEST_BIT_OP, BIO_SET_ONE_OP, BIO_SET_ZERO_OP};
    outp = k inside {BIO_SET_ONE_OP, BIO_SET_ZERO_OP, BIO_MULTI_BIT_LOAD_OP};
    bits = single ? 1 : ((n == 4'h0) ? 16 : int'(n));
    last_ea = single ? b + {{3{d[7]}}, d} : b;
    eo = single ? (k == BIO_SET_ONE_OP) : wd[0];
    op_kind = k;
    base_pointer_word = 16'hf001 | {4'h0, b, 1'b0};
    displacement = d;
    bit_count = n;
    write_data = wd;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    chk("bit_addr", {5'h00, last_ea}, {5'h00, bit_addr});
    chk("addr_top", 16'h0000, {14'h0, addr_top});
    if (outp) chk("serial_out", {15'h0, eo}, {15'h0, serial_bit_out});
    s = 0;
    t = 0;
    while (done !== 1'b1 && t < 64) begin
      @(posedge clk);
      #1;
      if (bit_output_strobe === 1'b1) s++;
      t++;
    end
    chk("done_cycle", 16'(2 * bits + 1), 16'(t + 1));
    chk("strobes", 16'(outp ? bits : 0), 16'(s));
  endtask

  task automatic t_single();
    for (int i = 0; i < 8; i++) begin
      run_op(BIO_TEST_BIT_OP, t_base[i], t_disp[i], 4'h0, 16'h0);
      chk("test_result", {15'h0, exp_in(last_ea)}, {15'h0, test_result});
    end
  endtask

  task automatic t_lamps();
    for (int i = 0; i < 4; i++) begin
      run_op(BIO_SET_ONE_OP, 11'h010, 8'(i), 4'h0, 16'h0);
    end
    chk("lamps_on", 16'h000f, {12'h0, lamps});
    run_op(BIO_SET_ZERO_OP, 11'h013, 8'hfe, 4'h0, 16'h0);
    run_op(BIO_SET_ZERO_OP, 11'h014, 8'h00, 4'h0, 16'h0);
    chk("lamps_held", 16'h000d, {12'h0, lamps});
  endtask

  task automatic t_store(input logic [10:0] b, input logic [3:0] n);
    logic [15:0] e;
    e = 16'h0;
    for (int k = 0; k < ((n == 4'h0) ? 16 : int'(n)); k++) begin
      e[k] = exp_in(b + 11'(k));
    end
    run_op(BIO_MULTI_BIT_STORE_OP, b, 8'h00, n, 16'h0);
    chk("read_data", e, read_data);
  endtask

  task automatic t_multi();
    run_op(BIO_MULTI_BIT_LOAD_OP, 11'h010, 8'h55, 4'h4, 16'hfff5);
    chk("lamps_load", 16'h0005, {12'h0, lamps});
    t_store(11'h1f8, 4'h0);
    t_store(11'h7fc, 4'h8);
  endtask

  task automatic t_mid_reset();
    run_op(BIO_SET_ONE_OP, 11'h012, 8'h00, 4'h0, 16'h0);
    op_kind = BIO_MULTI_BIT_LOAD_OP;
    base_pointer_word = 16'h0020;
    bit_count = 4'h0;
    write_data = 16'hffff;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b0;
    #1;
    chk("lamps_rst", 16'h0000, {12'h0, lamps});
    chk("ready_rst", 16'h0002, {14'h0, op_ready, busy});
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    run_op(BIO_TEST_BIT_OP, 11'h21f, 8'h00, 4'h0, 16'h0);
    chk("test_after_rst", 16'h0001, {15'h0, test_result});
    chk("lamps_after_rst", 16'h0000, {12'h0, lamps});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("idle", 16'h0004, {13'h0, op_ready, done, bit_output_strobe});
    t_single();
    t_lamps();
    t_multi();
    t_mid_reset();
    final_report();
  end
endmodule
`default_nettype wire
